//--- core/plld_pkg.sv
package plld_pkg;
    // Latch widths and serial word
    localparam int REF_R_W = 14;
    localparam int DIV_A_W = 7;
    localparam int DIV_N_W = 11;
    localparam int REF_LATCH_W = 15;
    localparam int DIV_LATCH_W = 18;
    localparam int SHIFT_W = 19;
    localparam int VCO_RATIO_W = 18;
    // Serial word field positions
    localparam int CTRL_BIT_POS = 0;
    localparam int REF_SW_POS = 15;
    localparam int DIV_N_LSB = 8;
    localparam int DIV_A_LSB = 1;
    // Valid ratio limits
    localparam logic [13:0] REF_R_MIN = 14'h0006;
    localparam logic [10:0] DIV_N_MIN = 11'h010;
    // Prescaler moduli shifts: 64 = 1<<6, 128 = 1<<7
    localparam int PRESC_SHIFT_LO = 6;
    localparam int PRESC_SHIFT_HI = 7;
    // Reset values
    localparam logic [13:0] REF_R_RST = 14'h0006;
    localparam logic REF_SW_RST = 1'b1;
    localparam logic [10:0] DIV_N_RST = 11'h010;
    localparam logic [6:0] DIV_A_RST = 7'h00;
    // APB register byte offsets
    localparam logic [11:0] REG_REF_OFS = 12'h000;
    localparam logic [11:0] REG_DIV_OFS = 12'h004;
    localparam logic [11:0] REG_STAT_OFS = 12'h008;
    // Register field positions
    localparam int REG_REF_SW_BIT = 14;
    localparam int REG_DIV_N_LSB = 7;
    localparam int STAT_POL_BIT = 0;
    localparam int STAT_UP_BIT = 1;
    localparam int STAT_DN_BIT = 2;
    localparam int STAT_FLAG_BIT = 3;
    localparam int STAT_REFUSED_BIT = 4;
endpackage

//--- core/plld_divider.sv
`timescale 1ns/10ps
module plld_divider #(
    parameter int W = 14
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic tick,
    input wire logic [W-1:0] ratio,
    output logic pulse
);
    logic [W-1:0] cnt_r;
    logic last;

    assign last = (cnt_r >= ratio - W'(1));

    // Counts ticks and pulses once per ratio ticks
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_r <= '0;
            pulse <= 1'b0;
        end
        else if (ce)
        begin
            pulse <= tick && last;
            if (tick)
            begin
                cnt_r <= last ? '0 : cnt_r + W'(1);
            end
        end
    end
endmodule // plld_divider

//--- core/plld_serial_loader.sv
`timescale 1ns/10ps
module plld_serial_loader (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic serial_clock,
    input wire logic serial_data,
    input wire logic latch_load_strobe,
    output logic ref_load,
    output logic [plld_pkg::REF_LATCH_W-1:0] ref_word,
    output logic div_load,
    output logic [plld_pkg::DIV_LATCH_W-1:0] div_word
);
    logic [plld_pkg::SHIFT_W-1:0] shift_r;
    logic sclk_q_r;
    logic load_q_r;
    logic sclk_rise;
    logic load_rise;

    assign sclk_rise = serial_clock && !sclk_q_r;
    assign load_rise = latch_load_strobe && !load_q_r;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sclk_q_r <= 1'b0;
            load_q_r <= 1'b0;
        end
        else if (ce)
        begin
            sclk_q_r <= serial_clock;
            load_q_r <= latch_load_strobe;
        end
    end

    // One bit per serial clock rising edge, first bit ends up highest
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            shift_r <= '0;
        end
        else if (ce && sclk_rise)
        begin
            shift_r <= {shift_r[plld_pkg::SHIFT_W-2:0], serial_data}; // RL3 RL11
        end
    end

    // Control bit, last one in, routes the word
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ref_load <= 1'b0;
            div_load <= 1'b0;
            ref_word <= '0;
            div_word <= '0;
        end
        else if (ce)
        begin
            ref_load <= load_rise && shift_r[plld_pkg::CTRL_BIT_POS]; // RL10
            div_load <= load_rise && !shift_r[plld_pkg::CTRL_BIT_POS]; // RL10
            if (load_rise)
            begin
                ref_word <= shift_r[plld_pkg::REF_SW_POS:1];
                div_word <= shift_r[plld_pkg::SHIFT_W-1:1];
            end
        end
    end

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    shift_one_a: assert property (ce && sclk_rise |=> shift_r[0] == $past(serial_data)) // RL3
        else $error("serial bit not captured");
    route_word_a: assert property (ce && load_rise |=> // RL10
        (ref_load == $past(shift_r[0])) && (div_load == !$past(shift_r[0])))
        else $error("word routed to wrong latch");
endmodule // plld_serial_loader

//--- core/plld_phase_ctrl.sv
// Register access over APB and the address map were decided locally.
`timescale 1ns/10ps
// Contract
// RL1: The reference ratio is 14 bits, valid from 6 to 16383, and smaller values are never loaded.
// RL2: The prescaler modulus is 64 or 128 by the ratio select bit and multiplies the counter value.
// RL3: Each serial clock rising edge shifts exactly one data bit into the shift register.
// RL4: With polarity high the pump drives high when reference leads, low when it lags, else floats.
// RL5: With polarity low the pump drives low when reference leads, high when it lags, else floats.
// RL6: With polarity high a reference lead pulls both phase outputs low, a lag drives ref high.
// RL7: With polarity low a lead drives the ref output high, a lag pulls both phase outputs low.
// RL8: The monitor copies the reference divided signal at polarity high, else the VCO one.
// RL9: The comparator tracks phase differences from minus two pi to plus two pi.
// RL10: On load, a high control bit fills the reference latch and a low one the divider latch.
// RL11: The host shifts words most significant bit first with the control bit last.
// RL12: The host programs the programmable counter only from 16 to 2047.
// RL13: The phase error flag is high and falls for the time the phase error lasts.
// RL14: The host keeps polarity select static to match the VCO tuning slope.
// RL15: An unconnected polarity select reads as high through its pull-up.
module plld_phase_ctrl (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic serial_clock,
    input wire logic serial_data,
    input wire logic latch_load_strobe,
    input wire logic phase_polarity_select,
    input wire logic vco_tick,
    output logic charge_pump_out,
    output logic charge_pump_oe,
    output logic ref_phase_out,
    output logic phase_od_out,
    output logic phase_od_oe,
    output logic phase_error_flag,
    output logic monitor_out
);
    logic [plld_pkg::REF_R_W-1:0] ref_r_r;
    logic prescaler_ratio_select_r;
    logic [plld_pkg::DIV_N_W-1:0] div_n_r;
    logic [plld_pkg::DIV_A_W-1:0] div_a_r;
    logic refused_r;
    logic up_r;
    logic dn_r;
    logic up_nxt;
    logic dn_nxt;
    logic ref_divided_signal;
    logic vco_divided_signal;
    logic ser_ref_load;
    logic ser_div_load;
    logic [plld_pkg::REF_LATCH_W-1:0] ser_ref_word;
    logic [plld_pkg::DIV_LATCH_W-1:0] ser_div_word;
    logic [plld_pkg::VCO_RATIO_W-1:0] vco_ratio;
    logic [plld_pkg::VCO_RATIO_W-1:0] n_scaled;
    logic pol;
    logic apb_wr;
    logic apb_rd;
    logic hit_ref;
    logic hit_div;
    logic hit_stat;
    logic [plld_pkg::REF_R_W-1:0] wr_r;
    logic [plld_pkg::DIV_N_W-1:0] wr_n;
    logic [plld_pkg::REF_R_W-1:0] ser_r;
    logic [plld_pkg::DIV_N_W-1:0] ser_n;

    // Pull-up on the pin makes an open input arrive here as high
    assign pol = phase_polarity_select; // RL15 RL14

    plld_serial_loader u_loader (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .serial_clock(serial_clock),
        .serial_data(serial_data),
        .latch_load_strobe(latch_load_strobe),
        .ref_load(ser_ref_load),
        .ref_word(ser_ref_word),
        .div_load(ser_div_load),
        .div_word(ser_div_word)
    );

    // APB decode
    assign pready = ce;
    assign apb_wr = psel && penable && pwrite && ce;
    assign apb_rd = psel && penable && !pwrite && ce;
    assign hit_ref = (paddr == plld_pkg::REG_REF_OFS);
    assign hit_div = (paddr == plld_pkg::REG_DIV_OFS);
    assign hit_stat = (paddr == plld_pkg::REG_STAT_OFS);
    assign wr_r = pwdata[plld_pkg::REF_R_W-1:0];
    assign wr_n = pwdata[plld_pkg::REG_DIV_N_LSB +: plld_pkg::DIV_N_W];
    assign ser_r = ser_ref_word[plld_pkg::REF_R_W-1:0];
    assign ser_n = ser_div_word[plld_pkg::DIV_N_LSB-1 +: plld_pkg::DIV_N_W];

    always_comb
    begin
        if (!(psel && penable))
        begin
            pslverr = 1'b0;
        end
        else if (hit_ref && pwrite)
        begin
            pslverr = (wr_r < plld_pkg::REF_R_MIN);
        end
        else if (hit_div && pwrite)
        begin
            pslverr = (wr_n < plld_pkg::DIV_N_MIN);
        end
        else if (hit_ref || hit_div || hit_stat)
        begin
            pslverr = 1'b0;
        end
        else
        begin
            pslverr = 1'b1;
        end
    end

    // Reference latch; ratios below the minimum are refused
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ref_r_r <= plld_pkg::REF_R_RST;
            prescaler_ratio_select_r <= plld_pkg::REF_SW_RST;
        end
        else if (ce)
        begin
            if (ser_ref_load && ser_r >= plld_pkg::REF_R_MIN) // RL1 RL10
            begin
                ref_r_r <= ser_r;
                prescaler_ratio_select_r <= ser_ref_word[plld_pkg::REG_REF_SW_BIT];
            end
            else if (apb_wr && hit_ref && wr_r >= plld_pkg::REF_R_MIN) // RL1
            begin
                ref_r_r <= wr_r;
                prescaler_ratio_select_r <= pwdata[plld_pkg::REG_REF_SW_BIT];
            end
        end
    end

    // Divider latch; counter values below 16 are refused
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            div_n_r <= plld_pkg::DIV_N_RST;
            div_a_r <= plld_pkg::DIV_A_RST;
        end
        else if (ce)
        begin
            if (ser_div_load && ser_n >= plld_pkg::DIV_N_MIN) // RL10 RL12
            begin
                div_n_r <= ser_n;
                div_a_r <= ser_div_word[plld_pkg::DIV_A_LSB-1 +: plld_pkg::DIV_A_W];
            end
            else if (apb_wr && hit_div && wr_n >= plld_pkg::DIV_N_MIN) // RL12
            begin
                div_n_r <= wr_n;
                div_a_r <= pwdata[plld_pkg::DIV_A_W-1:0];
            end
        end
    end

    // Sticky refusal flag; a new refusal wins over the clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            refused_r <= 1'b0;
        end
        else if (ce)
        begin
            if ((ser_ref_load && ser_r < plld_pkg::REF_R_MIN)
                || (ser_div_load && ser_n < plld_pkg::DIV_N_MIN)
                || (apb_wr && pslverr))
            begin
                refused_r <= 1'b1;
            end
            else if (apb_rd && hit_stat)
            begin
                refused_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= '0;
        end
        else if (ce && psel && !penable && !pwrite)
        begin
            if (paddr == plld_pkg::REG_REF_OFS)
            begin
                prdata <= {17'h00000, prescaler_ratio_select_r, ref_r_r};
            end
            else if (paddr == plld_pkg::REG_DIV_OFS)
            begin
                prdata <= {14'h0000, div_n_r, div_a_r};
            end
            else if (paddr == plld_pkg::REG_STAT_OFS)
            begin
                prdata <= {27'h0000000, refused_r, phase_error_flag, dn_r, up_r, pol};
            end
            else
            begin
                prdata <= '0;
            end
        end
    end

    // VCO ratio is modulus times counter plus swallow
    assign n_scaled = prescaler_ratio_select_r
        ? plld_pkg::VCO_RATIO_W'({div_n_r, 6'h00})
        : plld_pkg::VCO_RATIO_W'({div_n_r, 7'h00}); // RL2
    assign vco_ratio = n_scaled + plld_pkg::VCO_RATIO_W'(div_a_r);

    plld_divider #(.W(plld_pkg::REF_R_W)) u_ref_div (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .tick(1'b1),
        .ratio(ref_r_r),
        .pulse(ref_divided_signal)
    );

    plld_divider #(.W(plld_pkg::VCO_RATIO_W)) u_vco_div (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .tick(vco_tick),
        .ratio(vco_ratio),
        .pulse(vco_divided_signal)
    );

    // Phase-frequency detector; a repeated edge on one side keeps its flag (+-2pi)
    always_comb
    begin
        up_nxt = up_r || ref_divided_signal; // RL9
        dn_nxt = dn_r || vco_divided_signal; // RL9
        if (up_nxt && dn_nxt)
        begin
            up_nxt = 1'b0;
            dn_nxt = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            up_r <= 1'b0;
            dn_r <= 1'b0;
        end
        else if (ce)
        begin
            up_r <= up_nxt;
            dn_r <= dn_nxt;
        end
    end

    // Output steering by polarity
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            charge_pump_out <= 1'b0;
            charge_pump_oe <= 1'b0;
            ref_phase_out <= 1'b0;
            phase_od_out <= 1'b0;
            phase_od_oe <= 1'b0;
            phase_error_flag <= 1'b1;
            monitor_out <= 1'b0;
        end
        else if (ce)
        begin
            charge_pump_oe <= up_nxt || dn_nxt; // RL4 RL5
            charge_pump_out <= pol ? up_nxt : dn_nxt; // RL4 RL5
            ref_phase_out <= pol ? dn_nxt : up_nxt; // RL6 RL7
            phase_od_out <= 1'b0;
            phase_od_oe <= pol ? up_nxt : dn_nxt; // RL6 RL7
            phase_error_flag <= !(up_nxt || dn_nxt); // RL13
            monitor_out <= pol ? ref_divided_signal : vco_divided_signal; // RL8
        end
    end

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence ref_lead_s;
        up_r && !dn_r;
    endsequence
    sequence ref_lag_s;
        dn_r && !up_r;
    endsequence

    pump_lead_a: assert property (($stable(pol) and ref_lead_s) |-> // RL4
        charge_pump_oe && charge_pump_out == pol)
        else $error("pump wrong on reference lead");
    pump_lag_a: assert property (($stable(pol) and ref_lag_s) |-> // RL5
        charge_pump_oe && charge_pump_out == !pol)
        else $error("pump wrong on reference lag");
    pump_float_a: assert property (!up_r && !dn_r |-> !charge_pump_oe) // RL4 RL5
        else $error("pump driven when equal");
    phase_hi_pol_a: assert property (((pol && $stable(pol)) and ref_lead_s) |-> // RL6
        !ref_phase_out && phase_od_oe && !phase_od_out)
        else $error("phase outputs wrong at high polarity");
    phase_lo_pol_a: assert property (((!pol && $stable(pol)) and ref_lead_s) |-> // RL7
        ref_phase_out && !phase_od_oe)
        else $error("phase outputs wrong at low polarity");
    monitor_sel_a: assert property (ce && pol |=> monitor_out == $past(ref_divided_signal)) // RL8
        else $error("monitor not copying reference");
    error_flag_a: assert property (phase_error_flag == !(up_r || dn_r)) // RL13
        else $error("error flag not matching phase error");
    ref_min_a: assert property (ref_r_r >= plld_pkg::REF_R_MIN) // RL1
        else $error("reference ratio below minimum");
    prescale_a: assert property (ce && !prescaler_ratio_select_r |-> // RL2
        vco_ratio == {div_n_r, 7'h00} + plld_pkg::VCO_RATIO_W'(div_a_r))
        else $error("prescaler modulus not 128");
    pfd_clear_a: assert property (ce && up_r && vco_divided_signal && !ref_divided_signal |=> // RL9
        !up_r && !dn_r)
        else $error("detector not cleared when both edges seen");
    shift_bit_a: assert property (ce && serial_clock && !$past(serial_clock) |=> // RL3
        u_loader.shift_r == {$past(u_loader.shift_r[plld_pkg::SHIFT_W-2:0]),
        $past(serial_data)})
        else $error("serial bit not captured exactly once");
endmodule // plld_phase_ctrl

//--- testbench/plld_vco_model.sv
`timescale 1ns/10ps
// Open-loop VCO seen at the prescaler input: one tick every tick_period cycles,
// so the bench sets the frequency relation to the divided reference directly
module plld_vco_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [15:0] tick_period,
    output logic vco_tick
);
    logic [15:0] cnt_r;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_r <= 16'h0000;
            vco_tick <= 1'b0;
        end
        else if (cnt_r + 16'h0001 >= tick_period)
        begin
            cnt_r <= 16'h0000;
            vco_tick <= 1'b1;
        end
        else
        begin
            cnt_r <= cnt_r + 16'h0001;
            vco_tick <= 1'b0;
        end
    end
endmodule // plld_vco_model

//--- testbench/tb_top.sv
`timescale 1ns/10ps
module tb_top;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic ce = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic serial_clock = 1'b0;
    logic serial_data = 1'b0;
    logic latch_load_strobe = 1'b0;
    logic phase_polarity_select = 1'b1;
    logic [15:0] tick_period = 16'h0004;
    logic [31:0] prdata;
    logic pready, pslverr, vco_tick, charge_pump_out, charge_pump_oe, ref_phase_out;
    logic phase_od_out, phase_od_oe, phase_error_flag, monitor_out;
    int err_total = 0;
    int n_tests = 0;
    int seed = 95;
    logic [31:0] rd;
    logic sl;

    always #50 pclk = ~pclk;

    plld_phase_ctrl dut (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .serial_clock, .serial_data, .latch_load_strobe,
        .phase_polarity_select, .vco_tick, .charge_pump_out, .charge_pump_oe,
        .ref_phase_out, .phase_od_out, .phase_od_oe, .phase_error_flag, .monitor_out);

    plld_vco_model vco (.pclk, .presetn, .tick_period, .vco_tick);

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic report_and_stop;
        if (err_total == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    function automatic logic [31:0] ref_reg(input logic [13:0] r, input logic s);
        return {17'h0, s, r};
    endfunction

    function automatic logic [31:0] div_reg(input logic [10:0] n, input logic [6:0] a);
        return {14'h0, n, a};
    endfunction

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] q, output logic e);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic reg_chk(input logic [11:0] a, input logic [31:0] exp, input logic ee,
        input string what);
        apb(1'b0, a, 32'h0, rd, sl);
        chk(what, rd, exp);
        chk({what, " err"}, 32'(sl), 32'(ee));
    endtask

    // Host side: MSB first, control bit last, clock idle low between frames
    task automatic shift_word(input logic [18:0] word, input int nbits);
        for (int i = nbits - 1; i >= 0; i--)
        begin
            serial_data <= word[i];
            serial_clock <= 1'b0;
            repeat (2) @(posedge pclk);
            serial_clock <= 1'b1;
            repeat (2) @(posedge pclk);
        end
        serial_clock <= 1'b0;
        repeat (2) @(posedge pclk);
        latch_load_strobe <= 1'b1;
        repeat (4) @(posedge pclk);
        latch_load_strobe <= 1'b0;
        repeat (4) @(posedge pclk);
    endtask

    // One polarity and frequency relation held static for the whole run
    task automatic phase_run(input logic p, input logic fast);
        int mons;
        int act;
        int em;
        logic ex;
        mons = 0;
        act = 0;
        ex = !(p ^ fast);
        phase_polarity_select <= p;
        tick_period <= fast ? 16'h0004 : 16'h0001;
        apb(1'b1, plld_pkg::REG_DIV_OFS, div_reg(11'h010, 7'h00), rd, sl);
        apb(1'b1, plld_pkg::REG_REF_OFS, ref_reg(fast ? 14'h0006 : 14'h1000, p), rd, sl);
        repeat (5000) @(posedge pclk);
        repeat (8192)
        begin
            @(posedge pclk);
            mons += int'(monitor_out);
            if (charge_pump_oe === 1'b1)
            begin
                act++;
                chk("pump", 32'(charge_pump_out), 32'(ex));
                chk("ref phase", 32'(ref_phase_out), 32'(!ex));
                chk("od oe", 32'(phase_od_oe), 32'(ex));
            end
            else
            begin
                chk("ref phase idle", 32'(ref_phase_out), 32'h0);
                chk("od oe idle", 32'(phase_od_oe), 32'h0);
            end
            chk("od level", 32'(phase_od_out), 32'h0);
            chk("flag", 32'(phase_error_flag), 32'(!charge_pump_oe));
        end
        chk("pump active", 32'(act > 0), 32'h1);
        em = p ? 8192 / (fast ? 6 : 4096) : 8192 / ((fast ? 4 : 1) * (p ? 64 : 128) * 16);
        chk("monitor count", 32'(mons >= em - 1 && mons <= em + 1), 32'h1);
    endtask

    initial
    begin
        repeat (90000) @(posedge pclk);
        err_total++;
        report_and_stop();
    end

    initial
    begin
        logic [31:0] rv;
        logic [13:0] r14;
        logic [10:0] n11;
        logic ok_r;
        logic ok_n;
        logic [31:0] exp_ref;
        logic [31:0] exp_div;
        repeat (6) @(posedge pclk);
        chk("reset outs", {27'h0, charge_pump_oe, ref_phase_out, phase_od_oe,
            phase_error_flag, monitor_out}, 32'h2);
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        reg_chk(plld_pkg::REG_REF_OFS, ref_reg(14'h0006, 1'b1), 1'b0, "ref rst");
        reg_chk(plld_pkg::REG_DIV_OFS, div_reg(11'h010, 7'h00), 1'b0, "div rst");
        reg_chk(12'h00c, 32'h0, 1'b1, "unmapped");
        for (int i = 0; i < 4; i++)
            phase_run(i[0], i[1]);
        apb(1'b0, plld_pkg::REG_STAT_OFS, 32'h0, rd, sl);
        exp_ref = ref_reg(14'h0006, 1'b1);
        exp_div = div_reg(11'h010, 7'h00);
        for (int k = 0; k < 12; k++)
        begin
            rv = $random(seed);
            r14 = (k == 0) ? 14'h0006 : (k == 1) ? 14'h3fff : (k / 2 == 1) ? 14'h0005 : rv[13:0];
            n11 = (k == 0) ? 11'h010 : (k == 1) ? 11'h7ff : (k / 2 == 1) ? 11'h00f : rv[24:14];
            ok_r = r14 >= 14'h0006;
            ok_n = n11 >= 11'h010;
            if (k % 2 == 1)
            begin
                shift_word({3'h0, rv[0], r14, 1'b1}, 16);
                shift_word({n11, rv[31:25], 1'b0}, 19);
            end
            else
            begin
                apb(1'b1, plld_pkg::REG_REF_OFS, ref_reg(r14, rv[0]), rd, sl);
                chk("ref wr err", 32'(sl), 32'(!ok_r));
                apb(1'b1, plld_pkg::REG_DIV_OFS, div_reg(n11, rv[31:25]), rd, sl);
                chk("div wr err", 32'(sl), 32'(!ok_n));
            end
            if (ok_r)
                exp_ref = ref_reg(r14, rv[0]);
            if (ok_n)
                exp_div = div_reg(n11, rv[31:25]);
            reg_chk(plld_pkg::REG_REF_OFS, exp_ref, 1'b0, "ref");
            reg_chk(plld_pkg::REG_DIV_OFS, exp_div, 1'b0, "div");
            apb(1'b0, plld_pkg::REG_STAT_OFS, 32'h0, rd, sl);
            chk("refused", 32'(rd[4]), 32'(!(ok_r && ok_n)));
            apb(1'b0, plld_pkg::REG_STAT_OFS, 32'h0, rd, sl);
            chk("refused clr", 32'(rd[4]), 32'h0);
        end
        // Clock enable low freezes outputs and holds the bus not ready
        repeat (3000) @(posedge pclk);
        ce <= 1'b0;
        @(posedge pclk);
        rv = {26'h0, pready, charge_pump_oe, charge_pump_out, ref_phase_out, phase_od_oe,
            monitor_out};
        repeat (40) @(posedge pclk);
        chk("ce freeze", {26'h0, pready, charge_pump_oe, charge_pump_out, ref_phase_out,
            phase_od_oe, monitor_out}, rv);
        chk("pready frozen", 32'(pready), 32'h0);
        ce <= 1'b1;
        @(posedge pclk);
        report_and_stop();
    end
endmodule // tb_top
